// *** verilog/clk_pwr_ctrl.sv ***
/*
 * sample clock divider with alignment, duty cycle stabilizer model and
 * power state control.
 * assumes clk is the sample clock, config writes are one-cycle strobes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "clk_pwr_consts.svh"
// Operation
// [R1] divide the sample clock by any integer ratio from one to eight
// [R2] ratios one, two and four work with stabilizer on or off
// [R3] software must enable the stabilizer for ratios three, five to eight
// [R4] bits 1 and 2 of config 0x100 pick every or first alignment
// [R5] an accepted alignment pulse resets the divider counter
// [R6] alignment input passes a two flop synchroniser first
// [R7] external alignment input changes in step with the sample clock
// [R8] stabilizer keeps rising edge, regenerates falling edge near 50 percent
// [R9] stabilizer is inactive below about twenty megahertz
// [R10] system waits 1.5 to 5 us after rate changes for relock
// [R11] stabilizer is bypassed while its loop is unlocked
// [R12] power down on pin high or config request
// [R13] data output drivers are high impedance during power down
// [R14] pin low returns the device to normal operation
// [R15] power down stops reference, bias and clock; wake needs recharge
// [R16] config standby keeps reference on and wakes faster
// [R17] single alignment arms on mode write, disarms after first pulse
// [R18] power down is pin or config; standby only without power down
module clk_pwr_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] div_sel,
   input wire logic dcs_enable,
   input wire logic dcs_locked,
   input wire logic [7:0] clk_rate_mhz,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic align_in,
   input wire logic power_down_pin,
   input wire logic cfg_power_down,
   input wire logic cfg_standby,
   output logic conv_clk,
   output logic conv_rise,
   output logic dcs_active,
   output logic dcs_warn,
   output logic align_armed,
   output logic align_pulse,
   output logic data_oe,
   output logic ref_on,
   output logic bias_on,
   output logic clk_on,
   output logic conv_valid,
   output logic [1:0] pwr_state
);
   localparam logic [`WAKE_W-1:0] WAKE_PD =
      `WAKE_W'(`WAKE_PD_CYC);
   localparam logic [`WAKE_W-1:0] WAKE_SB =
      `WAKE_W'(`WAKE_SB_CYC);

   function automatic logic dcs_needed(input logic [3:0] r);
      dcs_needed = !(r == 4'h1 || r == 4'h2 || r == 4'h4);
   endfunction

   logic sync_en_q, sync_once_q, armed_q;
   logic align_s, align_d1_q, align_rise, align_take;
   logic [3:0] cnt_q, cnt_d, ratio, half_hi;
   logic conv_clk_q, conv_rise_q, dcs_act_q, dcs_warn_q;
   logic align_pulse_q, data_oe_q, ref_q, bias_q, clk_on_q, valid_q;
   clk_pwr_pkg::pwr_state_t st_q, st_d;
   logic [`WAKE_W-1:0] wake_q, wake_d;
   logic pd_req, sb_req, mode_wr, dcs_use;

   sync_2ff u_align_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(align_in), // R6
      .q(align_s)
   );

   assign ratio = {1'b0, div_sel} + 4'h1; // R1
   assign mode_wr = cfg_wr && cfg_addr == `CFG_SYNC_ADDR;
   assign align_rise = align_s && !align_d1_q;
   assign align_take = align_rise && sync_en_q &&
      (!sync_once_q || armed_q); // R4
   assign dcs_use = dcs_enable && dcs_locked &&
      clk_rate_mhz >= 8'(`DCS_MIN_MHZ); // R9 R11
   // with stabilizer and ratio above one high half is ratio/2, else the raw pattern of one
   assign half_hi = dcs_use && ratio != 4'h1 ? (ratio >> 1) : 4'h1; // R8
   assign pd_req = power_down_pin || cfg_power_down; // R12 R18
   assign sb_req = cfg_standby && !pd_req; // R16 R18

   always_comb begin
      cnt_d = cnt_q + 4'h1;
      if (align_take || cnt_q >= ratio - 4'h1) begin
         cnt_d = 4'h0; // R5
      end
   end

   always_comb begin
      st_d = st_q;
      wake_d = wake_q;
      unique case (st_q)
         clk_pwr_pkg::PWR_RUN: begin
            if (pd_req) st_d = clk_pwr_pkg::PWR_DOWN;
            else if (sb_req) st_d = clk_pwr_pkg::PWR_STANDBY;
         end
         clk_pwr_pkg::PWR_STANDBY: begin
            if (pd_req) st_d = clk_pwr_pkg::PWR_DOWN;
            else if (!sb_req) begin
               st_d = clk_pwr_pkg::PWR_WAKE;
               wake_d = WAKE_SB; // R16
            end
         end
         clk_pwr_pkg::PWR_DOWN: begin
            if (sb_req) begin
               st_d = clk_pwr_pkg::PWR_STANDBY; // R18
            end else if (!pd_req) begin
               st_d = clk_pwr_pkg::PWR_WAKE; // R14
               wake_d = WAKE_PD; // R15
            end
         end
         clk_pwr_pkg::PWR_WAKE: begin
            if (pd_req) st_d = clk_pwr_pkg::PWR_DOWN;
            else if (sb_req) st_d = clk_pwr_pkg::PWR_STANDBY;
            else if (wake_q <= `WAKE_W'(1)) st_d = clk_pwr_pkg::PWR_RUN;
            else wake_d = wake_q - `WAKE_W'(1);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_en_q <= 1'b0;
         sync_once_q <= 1'b0;
         armed_q <= 1'b0;
         align_d1_q <= 1'b0;
      end else begin
         align_d1_q <= align_s;
         if (mode_wr) begin
            sync_en_q <= cfg_wdata[`SYNC_EN_BIT];
            sync_once_q <= cfg_wdata[`SYNC_ONCE_BIT];
            armed_q <= 1'b1; // R17
         end else if (align_take && sync_once_q) begin
            armed_q <= 1'b0; // R17
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || st_q != clk_pwr_pkg::PWR_RUN &&
          st_q != clk_pwr_pkg::PWR_WAKE) begin
         cnt_q <= 4'h0; // R15
         conv_clk_q <= 1'b0;
         conv_rise_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         conv_clk_q <= cnt_d < half_hi;
         conv_rise_q <= cnt_d == 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= clk_pwr_pkg::PWR_RUN;
         wake_q <= '0;
         dcs_act_q <= 1'b0;
         dcs_warn_q <= 1'b0;
         align_pulse_q <= 1'b0;
         data_oe_q <= 1'b0;
         ref_q <= 1'b0;
         bias_q <= 1'b0;
         clk_on_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wake_q <= wake_d;
         dcs_act_q <= dcs_use;
         dcs_warn_q <= dcs_needed(ratio) && !dcs_enable; // R2 R3
         align_pulse_q <= align_take;
         data_oe_q <= st_d != clk_pwr_pkg::PWR_DOWN; // R13
         ref_q <= st_d != clk_pwr_pkg::PWR_DOWN; // R16
         bias_q <= st_d == clk_pwr_pkg::PWR_RUN ||
            st_d == clk_pwr_pkg::PWR_WAKE;
         clk_on_q <= st_d == clk_pwr_pkg::PWR_RUN ||
            st_d == clk_pwr_pkg::PWR_WAKE;
         valid_q <= st_d == clk_pwr_pkg::PWR_RUN; // R15
      end
   end

   assign conv_clk = conv_clk_q;
   assign conv_rise = conv_rise_q;
   assign dcs_active = dcs_act_q;
   assign dcs_warn = dcs_warn_q;
   assign align_armed = armed_q;
   assign align_pulse = align_pulse_q;
   assign data_oe = data_oe_q;
   assign ref_on = ref_q;
   assign bias_on = bias_q;
   assign clk_on = clk_on_q;
   assign conv_valid = valid_q;
   assign pwr_state = st_q;

   property p_pd_oe;
      @(posedge clk) disable iff (sys_rst)
      pd_req |=> !data_oe;
   endproperty
   a_pd_oe: assert property (p_pd_oe) else $error("oe on in power down"); // R13

   property p_pd_state;
      @(posedge clk) disable iff (sys_rst)
      pd_req |=> pwr_state == 2'(clk_pwr_pkg::PWR_DOWN);
   endproperty
   a_pd_state: assert property (p_pd_state) else $error("no power down"); // R12

   property p_wake;
      @(posedge clk) disable iff (sys_rst)
      $fell(pd_req) && !cfg_standby |=> !conv_valid [*8];
   endproperty
   a_wake: assert property (p_wake) else $error("valid too soon"); // R15

   // wake count from power down plus two register stages
   localparam int RET_MAX = `WAKE_PD_CYC + 2;

   property p_ret;
      @(posedge clk) disable iff (sys_rst)
      $fell(pd_req) && !cfg_standby |->
         ##[1:RET_MAX] (conv_valid || pd_req || cfg_standby);
   endproperty
   a_ret: assert property (p_ret) else $error("no return to run"); // R14

   property p_align;
      @(posedge clk) disable iff (sys_rst)
      align_take && pwr_state == 2'(clk_pwr_pkg::PWR_RUN) |=> cnt_q == 4'h0;
   endproperty
   a_align: assert property (p_align) else $error("divider not reset"); // R5

   property p_once;
      @(posedge clk) disable iff (sys_rst)
      align_take && sync_once_q && !mode_wr |=> !align_armed;
   endproperty
   a_once: assert property (p_once) else $error("still armed"); // R17

   property p_div;
      @(posedge clk) disable iff (sys_rst)
      pwr_state == 2'(clk_pwr_pkg::PWR_RUN) && $stable(div_sel) |->
         cnt_q < ratio;
   endproperty
   a_div: assert property (p_div) else $error("counter past ratio"); // R1

   property p_dcs;
      @(posedge clk) disable iff (sys_rst)
      clk_rate_mhz < 8'(`DCS_MIN_MHZ) |=> !dcs_active;
   endproperty
   a_dcs: assert property (p_dcs) else $error("stabilizer active slow"); // R9

   property p_sb;
      @(posedge clk) disable iff (sys_rst)
      sb_req |=> ref_on && !bias_on;
   endproperty
   a_sb: assert property (p_sb) else $error("standby levels wrong"); // R16
endmodule
`default_nettype wire

// *** verilog/clk_pwr_consts.svh ***
/*
 * constants for the sample clock divider, alignment and power control.
 * assumes inclusion by the main module only; the package does not include it.
 */
`ifndef CLK_PWR_CONSTS_SVH
`define CLK_PWR_CONSTS_SVH
`define CFG_SYNC_ADDR 12'h100
`define SYNC_EN_BIT 1
`define SYNC_ONCE_BIT 2
`define DIV_MIN 4'h1
`define DIV_MAX 4'h8
`define DCS_MIN_MHZ 20
`define CLK_MHZ 25
`define WAKE_PD_NS 2000
`define WAKE_SB_NS 200
`define CLK_NS 40
`define WAKE_PD_CYC ((`WAKE_PD_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_SB_CYC ((`WAKE_SB_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_W 7
`endif

// *** verilog/clk_pwr_pkg.sv ***
/*
 * types for the sample clock block.
 * assumes nothing beyond the constants header.
 */
package clk_pwr_pkg;
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_STANDBY,
      PWR_DOWN,
      PWR_WAKE
   } pwr_state_t;
endpackage

// *** verilog/sync_2ff.sv ***
/*
 * two flop synchroniser for one level.
 * assumes d may change at any time relative to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module sync_2ff (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** test/align_src.sv ***
/*
 sample clock source side: alignment pulse driver and stabilizer lock model.
 assumes clk is the sample clock and fire is a one-cycle request.
*/
`timescale 1ns/100ps
`default_nettype none
module align_src #(
   parameter int LOCK_CYC = 50
) (
   input wire logic clk,
   input wire logic fire,
   input wire logic [7:0] rate,
   output logic align_in,
   output logic dcs_locked
);
   logic [7:0] last_q = 8'h00;
   int cnt_q = 0;
   logic [1:0] hi_q = 2'h0;
   always_ff @(posedge clk) begin
      last_q <= rate;
      if (rate != last_q || rate < 8'h14) begin
         cnt_q <= 0;
      end else if (cnt_q < LOCK_CYC) begin
         cnt_q <= cnt_q + 1;
      end
      hi_q <= fire ? 2'h2 : ((hi_q != 2'h0) ? hi_q - 2'h1 : 2'h0);
   end
   // lock held off about 2 us after any rate change
   assign dcs_locked = cnt_q >= LOCK_CYC;
   assign align_in = hi_q != 2'h0;
endmodule
`default_nettype wire

// *** test/tb.sv ***
/*
 bench for clk_pwr_ctrl: divider, stabilizer, alignment and power states.
 assumes align_src stands for the clock source and alignment logic.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk, sys_rst, dcs_enable, dcs_locked, cfg_wr, align_in, fire;
   logic power_down_pin, cfg_power_down, cfg_standby;
   logic [2:0] div_sel;
   logic [7:0] clk_rate_mhz, cfg_wdata;
   logic [11:0] cfg_addr;
   logic conv_clk, conv_rise, dcs_active, dcs_warn, align_armed, align_pulse;
   logic data_oe, ref_on, bias_on, clk_on, conv_valid;
   logic [1:0] pwr_state;
   int errors, compares, n;
   clk_pwr_ctrl i_dut (.clk, .sys_rst, .div_sel, .dcs_enable, .dcs_locked,
      .clk_rate_mhz, .cfg_wr, .cfg_addr, .cfg_wdata, .align_in,
      .power_down_pin, .cfg_power_down, .cfg_standby, .conv_clk, .conv_rise,
      .dcs_active, .dcs_warn, .align_armed, .align_pulse, .data_oe, .ref_on,
      .bias_on, .clk_on, .conv_valid, .pwr_state);
   align_src i_src (.clk, .fire, .rate(clk_rate_mhz), .align_in, .dcs_locked);
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic to_rise(output int k);
      k = 0;
      do begin
         cyc(1);
         k++;
      end while (conv_rise !== 1'b1 && k < 20);
      if (k >= 20) begin
         errors++;
         close_out();
      end
   endtask
   // high cycles of conv_clk over p cycles
   task automatic hi_cnt(input int p, output int h);
      h = 0;
      repeat (p) begin
         cyc(1);
         if (conv_clk === 1'b1) h++;
      end
   endtask
   task automatic cfg(input logic [11:0] a, input logic [7:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(1);
   endtask
   // one alignment pulse, then look for acceptance
   task automatic sync(input logic e);
      logic seen, rise;
      seen = 1'b0;
      rise = 1'b0;
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         if (align_pulse === 1'b1) begin
            seen = 1'b1;
            rise = conv_rise;
         end
      end
      chk("align_pulse", {7'h0, e}, {7'h0, seen});
      chk("conv_rise", {7'h0, e}, {7'h0, rise});
   endtask
   task automatic wait_state(input logic [1:0] s, input int lim);
      int k;
      k = 0;
      while (pwr_state !== s && k < lim) begin
         cyc(1);
         k++;
      end
      if (k >= lim) begin
         errors++;
         close_out();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {sys_rst, dcs_enable} = 2'h3;
      {cfg_wr, fire, power_down_pin, cfg_power_down, cfg_standby} = 5'h00;
      div_sel = 3'h0;
      clk_rate_mhz = 8'h19;
      cfg_addr = 12'h000;
      cfg_wdata = 8'h00;
      errors = 0;
      compares = 0;
      cyc(12);
      sys_rst = 1'b0;
      cyc(60);
      chk("pwr_state", 8'h0, {6'h0, pwr_state});
      chk("dcs_active", 8'h1, {7'h0, dcs_active});
      for (int r = 0; r < 8; r++) begin
         div_sel = r[2:0];
         to_rise(n);
         to_rise(n);
         chk("period", 8'(r + 1), 8'(n));
         hi_cnt(r + 1, n);
         chk("conv_clk", 8'(r == 0 ? 1 : (r + 1) / 2), 8'(n));
      end
      dcs_enable = 1'b0;
      for (int r = 0; r < 8; r++) begin
         div_sel = r[2:0];
         cyc(3);
         chk("dcs_warn", 8'(r == 2 || r >= 4), {7'h0, dcs_warn});
      end
      dcs_enable = 1'b1;
      clk_rate_mhz = 8'h0a;
      cyc(3);
      chk("dcs_active", 8'h0, {7'h0, dcs_active});
      clk_rate_mhz = 8'h19;
      cyc(3);
      chk("dcs_active", 8'h0, {7'h0, dcs_active});
      to_rise(n);
      hi_cnt(8, n);
      chk("conv_clk", 8'h1, 8'(n));
      cyc(60);
      chk("dcs_active", 8'h1, {7'h0, dcs_active});
      div_sel = 3'h3;
      cfg(12'h100, 8'h06);
      chk("align_armed", 8'h1, {7'h0, align_armed});
      sync(1'b1);
      chk("align_armed", 8'h0, {7'h0, align_armed});
      sync(1'b0);
      cfg(12'h0ff, 8'h06);
      chk("align_armed", 8'h0, {7'h0, align_armed});
      cfg(12'h100, 8'h02);
      sync(1'b1);
      sync(1'b1);
      cfg(12'h100, 8'h00);
      sync(1'b0);
      power_down_pin = 1'b1;
      cyc(2);
      chk("pwr_state", 8'h2, {6'h0, pwr_state});
      chk("data_oe", 8'h0, {7'h0, data_oe});
      chk("power", 8'h0, {5'h0, ref_on, bias_on, clk_on});
      chk("conv_valid", 8'h0, {7'h0, conv_valid});
      power_down_pin = 1'b0;
      cyc(2);
      chk("pwr_state", 8'h3, {6'h0, pwr_state});
      wait_state(2'h0, 60);
      chk("conv_valid", 8'h1, {7'h0, conv_valid});
      cfg_standby = 1'b1;
      cyc(2);
      chk("pwr_state", 8'h1, {6'h0, pwr_state});
      chk("power", 8'h4, {5'h0, ref_on, bias_on, clk_on});
      cfg_standby = 1'b0;
      wait_state(2'h0, 10);
      {cfg_standby, cfg_power_down} = 2'h3;
      cyc(2);
      chk("pwr_state", 8'h2, {6'h0, pwr_state});
      chk("data_oe", 8'h0, {7'h0, data_oe});
      cfg_power_down = 1'b0;
      cyc(2);
      chk("pwr_state", 8'h1, {6'h0, pwr_state});
      cfg_standby = 1'b0;
      wait_state(2'h0, 60);
      close_out();
   end
endmodule
`default_nettype wire
